// *** src/cerr_top.sv ***
// Error reporting core: boot-up, emergency frames, status, SDO aborts.
// Assumes an APB master and a CAN controller taking frames by valid/ready.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/100ps
module cerr_top
  import cerr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frames to the CAN controller
  output cerr_pkg::cerr_frame_t tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  // Hardware event strobes, one per emergency code/sub pair
  input wire logic [cerr_pkg::CERR_NEV-1:0] ev_strobe,
  // Internal controller read result strobes
  input wire logic rd_fail,
  input wire logic rd_ok,
  // Status word and error register as sent in PDOs
  output logic [15:0] pdo_status,
  output logic [15:0] pdo_detail,
  output logic [7:0] err_register
);
  typedef enum logic [1:0] {
    CERR_S_BOOT = 2'b00, CERR_S_IDLE = 2'b01, CERR_S_SEND = 2'b11
  } cerr_state_t;

  cerr_state_t state_r, state_nxt;
  cerr_frame_t frame_r, frame_nxt;
  logic valid_r, valid_nxt;
  logic [CERR_NEV-1:0] pend_r, pend_nxt;
  logic [6:0] node_r, node_nxt;
  logic [15:0] status_r, status_nxt;
  logic [15:0] detail_r, detail_nxt;
  logic [7:0] errreg_r, errreg_nxt;
  logic [2:0] fails_r, fails_nxt;
  logic [3:0] cause_r, cause_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic abort_req;
  logic [31:0] abort_code;
  logic abort_valid;
  logic [31:0] abort_held_r, abort_held_nxt;
  logic pick_found;
  logic [4:0] pick_index;
  logic [4:0] sent_index_r, sent_index_nxt;
  logic [CERR_NEV-1:0] ev_all;
  logic func_err;
  logic wr_acc, rd_acc, setup;

  // Access phase of an APB transfer, answered one cycle after setup
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready_r;
  assign rd_acc = psel && penable && !pwrite && pready_r;
  assign abort_req = wr_acc && paddr == CERR_OFF_SDOREQ;

  // Read failure counter raises its own event past the limit
  // Count saturates at the limit, so each further fail raises it again
  always_comb begin
    fails_nxt = fails_r;
    ev_all = ev_strobe;
    if (rd_ok) begin
      fails_nxt = 3'h0;
    end else if (rd_fail) begin
      if (fails_r == CERR_READ_FAIL_MAX) begin
        ev_all[CERR_EV_READ_FAIL] = 1'b1;
      end else begin
        fails_nxt = fails_r + 3'h1;
      end
    end
  end

  cerr_emcy_pick #(.NEV(CERR_NEV)) u_pick (
    .pending(pend_r),
    .found(pick_found),
    .index(pick_index)
  );

  cerr_abort u_abort (
    .pclk(pclk),
    .presetn(presetn),
    .req(abort_req),
    .cause(pwdata[3:0]),
    .code(abort_code),
    .valid(abort_valid)
  );

  // Frame sequencer: boot-up first, then pending emergencies
  always_comb begin
    state_nxt = state_r;
    frame_nxt = frame_r;
    valid_nxt = valid_r;
    sent_index_nxt = sent_index_r;
    pend_nxt = pend_r | ev_all; // New events win over the clear below
    unique case (state_r)
      CERR_S_BOOT: begin
        if (!valid_r) begin
          frame_nxt.cob_id = CERR_COB_BOOT + 11'(node_r);
          frame_nxt.dlc = CERR_DLC_BOOT;
          frame_nxt.data = 64'h0000000000000000;
          valid_nxt = 1'b1;
        end else if (tx_ready) begin
          valid_nxt = 1'b0;
          state_nxt = CERR_S_IDLE;
        end
      end
      CERR_S_IDLE: begin
        if (pick_found) begin
          frame_nxt.cob_id = CERR_COB_EMCY + 11'(node_r);
          frame_nxt.dlc = CERR_DLC_EMCY;
          // Little-endian code, register, four unused bytes, sub code
          frame_nxt.data = {CERR_EV_SUB[pick_index], 32'h00000000, errreg_r,
                            CERR_EV_CODE[pick_index][15:8],
                            CERR_EV_CODE[pick_index][7:0]};
          valid_nxt = 1'b1;
          sent_index_nxt = pick_index;
          state_nxt = CERR_S_SEND;
        end
      end
      CERR_S_SEND: begin
        if (tx_ready) begin
          valid_nxt = 1'b0;
          state_nxt = CERR_S_IDLE;
          if (!ev_all[sent_index_r]) begin
            pend_nxt[sent_index_r] = 1'b0;
          end
        end
      end
      // Unused code 2'b10 falls back to idle, dropping any half frame
      default: begin
        valid_nxt = 1'b0;
        state_nxt = CERR_S_IDLE;
      end
    endcase
  end

  // Node identifier from control register, zero kept out
  // A zero write would leave the node unreachable, so it is dropped
  always_comb begin
    node_nxt = node_r;
    if (wr_acc && paddr == CERR_OFF_CTRL && pwdata[CERR_CTRL_NODE_LSB +: 7] != 7'h00) begin
      node_nxt = pwdata[CERR_CTRL_NODE_LSB +: 7];
    end
  end

  // Functional error: nonzero detail code written by firmware
  always_comb begin
    detail_nxt = detail_r;
    if (wr_acc && paddr == CERR_OFF_FAULT) begin
      detail_nxt = pwdata[15:0];
    end
    func_err = detail_nxt != 16'h0000;
    status_nxt = status_r;
    if (wr_acc && paddr == CERR_OFF_STATUS) begin
      status_nxt = pwdata[15:0];
    end
    status_nxt[CERR_STAT_FUNC_BIT] = func_err;
    errreg_nxt = errreg_r;
    if (wr_acc && paddr == CERR_OFF_ERRREG) begin
      errreg_nxt = pwdata[7:0];
    end
    errreg_nxt[CERR_ERRREG_MFR_BIT] = func_err;
  end

  // Abort code held for software to place in the SDO reply
  // Held until the next request, since software reads it later
  always_comb begin
    abort_held_nxt = abort_held_r;
    if (abort_valid) begin
      abort_held_nxt = abort_code;
    end
  end

  // APB read mux, no wait states
  // Decoding in setup keeps prdata a flop that stands with pready
  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h00000000;
    if (setup) begin
      unique case (paddr)
        CERR_OFF_CTRL: prdata_nxt = {25'h0000000, node_r};
        CERR_OFF_EVENT: prdata_nxt = {12'h000, pend_r};
        CERR_OFF_FAULT: prdata_nxt = {16'h0000, detail_r};
        CERR_OFF_STATUS: prdata_nxt = {16'h0000, status_r};
        CERR_OFF_ERRREG: prdata_nxt = {24'h000000, errreg_r};
        CERR_OFF_DETAIL: prdata_nxt = {27'h0000000, fails_r, state_r};
        CERR_OFF_SDOREQ: prdata_nxt = {28'h0000000, cause_r};
        CERR_OFF_ABORT: prdata_nxt = abort_held_r;
        CERR_OFF_TXID: prdata_nxt = {17'h00000, frame_r.cob_id, frame_r.dlc};
        CERR_OFF_TXLO: prdata_nxt = frame_r.data[31:0];
        CERR_OFF_TXHI: prdata_nxt = frame_r.data[63:32];
        CERR_OFF_TXCTL: prdata_nxt = {31'h00000000, valid_r};
        CERR_OFF_PDO: prdata_nxt = {detail_r, status_r};
        default: pslverr_nxt = 1'b1;
      endcase
    end
    cause_nxt = abort_req ? pwdata[3:0] : cause_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CERR_S_BOOT;
      frame_r <= '0;
      valid_r <= 1'b0;
      sent_index_r <= 5'h00;
      pend_r <= '0;
      node_r <= CERR_NODE_RST;
      status_r <= 16'h0000;
      detail_r <= 16'h0000;
      errreg_r <= 8'h00;
      fails_r <= 3'h0;
      cause_r <= 4'h0;
      abort_held_r <= 32'h00000000;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      frame_r <= frame_nxt;
      valid_r <= valid_nxt;
      sent_index_r <= sent_index_nxt;
      pend_r <= pend_nxt;
      node_r <= node_nxt;
      status_r <= status_nxt;
      detail_r <= detail_nxt;
      errreg_r <= errreg_nxt;
      fails_r <= fails_nxt;
      cause_r <= cause_nxt;
      abort_held_r <= abort_held_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_frame = frame_r;
  assign tx_valid = valid_r;
  assign pdo_status = status_r;
  assign pdo_detail = detail_r;
  assign err_register = errreg_r;

  // Boot-up and emergency frame checks
  a_boot_first: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(tx_valid) && state_r == CERR_S_BOOT |-> tx_frame.cob_id[10:7] == 4'hE)
    else $error("boot frame id wrong");
  a_boot_once: assert property (@(posedge pclk) disable iff (!presetn)
    state_r != CERR_S_BOOT |=> state_r != CERR_S_BOOT)
    else $error("boot state entered again");
  a_frame_held: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("frame dropped or changed while waiting");
  a_emcy_id: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && state_r == CERR_S_SEND |-> tx_frame.cob_id == 11'h080 + 11'(node_r))
    else $error("emergency id wrong");
  a_emcy_len: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && state_r == CERR_S_SEND |-> tx_frame.dlc == 4'h8 &&
    tx_frame.data[55:24] == 32'h0 && tx_frame.data[23:16] == errreg_r)
    else $error("emergency layout wrong");
  a_emcy_code: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && state_r == CERR_S_SEND |->
    tx_frame.data[15:0] == CERR_EV_CODE[sent_index_r] &&
    tx_frame.data[63:56] == CERR_EV_SUB[sent_index_r])
    else $error("emergency code or sub code wrong");
  a_pend_clear: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == CERR_S_SEND && tx_ready && !ev_all[sent_index_r] |=> !pend_r[sent_index_r])
    else $error("sent event still pending");
  a_event_kept: assert property (@(posedge pclk) disable iff (!presetn)
    ev_strobe[0] |=> pend_r[0]) else $error("event lost");

  // Status, counter, node, register bus and abort code checks
  a_status_bit: assert property (@(posedge pclk) disable iff (!presetn)
    pdo_status[14] == (pdo_detail != 16'h0000)) else $error("status bit 14 wrong");
  a_errreg_bit: assert property (@(posedge pclk) disable iff (!presetn)
    err_register[7] == pdo_status[14]) else $error("error register bit 7 wrong");
  a_fail_limit: assert property (@(posedge pclk) disable iff (!presetn)
    rd_fail && !rd_ok && fails_r == 3'h3 |=> pend_r[15]) else $error("8310/04 missed");
  a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ok |=> fails_r == 3'h0) else $error("fail count not cleared");
  a_node_legal: assert property (@(posedge pclk) disable iff (!presetn)
    node_r != 7'h00) else $error("node identifier zero");
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready) else $error("read answer late");
  a_abort_start: assert property (@(posedge pclk) disable iff (!presetn)
    abort_req |=> abort_valid) else $error("abort lookup not started");
  a_abort_seen: assert property (@(posedge pclk) disable iff (!presetn)
    abort_req && pwdata[3:0] == 4'h4 |=> ##1 abort_held_r == 32'h06020000)
    else $error("abort code wrong");
endmodule // cerr_top

// *** src/cerr_pkg.sv ***
// Package for the error reporting block: constants, codes, carriers.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
// Functional notes
// - Send boot-up frame once after power-on
// - Emergency frame identifier is 80h plus node
// - Failed SDO answered with abort code
// - Functional error sets status word bit 14
// - Functional error sets error register bit 7
// - Detail and status readable at 204E subs
// - Bus emergency codes 8100 to 8150, sub 00
// - Application codes 82xx with listed subs
// - Controller link codes 83xx with listed subs
// - More than three read failures raise 8310/04
// - Access abort codes 0601000xh
// - Missing object or sub-index abort codes
// - Range and too-large value abort codes
// - Command, overflow and general abort codes
// - Storage request abort codes
// - Detail shown by SDO and in PDOs
package cerr_pkg;
  // Register byte offsets
  localparam logic [7:0] CERR_OFF_CTRL = 8'h00;
  localparam logic [7:0] CERR_OFF_EVENT = 8'h04;
  localparam logic [7:0] CERR_OFF_FAULT = 8'h08;
  localparam logic [7:0] CERR_OFF_STATUS = 8'h0C;
  localparam logic [7:0] CERR_OFF_ERRREG = 8'h10;
  localparam logic [7:0] CERR_OFF_DETAIL = 8'h14;
  localparam logic [7:0] CERR_OFF_SDOREQ = 8'h18;
  localparam logic [7:0] CERR_OFF_ABORT = 8'h1C;
  localparam logic [7:0] CERR_OFF_TXID = 8'h20;
  localparam logic [7:0] CERR_OFF_TXLO = 8'h24;
  localparam logic [7:0] CERR_OFF_TXHI = 8'h28;
  localparam logic [7:0] CERR_OFF_TXCTL = 8'h2C;
  localparam logic [7:0] CERR_OFF_PDO = 8'h30;
  // Field positions and reset values
  localparam int CERR_STAT_FUNC_BIT = 14;
  localparam int CERR_ERRREG_MFR_BIT = 7;
  localparam int CERR_CTRL_NODE_LSB = 0;
  localparam logic [6:0] CERR_NODE_RST = 7'h01;
  localparam logic [10:0] CERR_COB_EMCY = 11'h080;
  localparam logic [10:0] CERR_COB_BOOT = 11'h700;
  localparam logic [3:0] CERR_DLC_EMCY = 4'h8;
  localparam logic [3:0] CERR_DLC_BOOT = 4'h1;
  localparam logic [2:0] CERR_READ_FAIL_MAX = 3'h3;
  localparam logic [7:0] CERR_SUB_NONE = 8'h00;
  // Emergency event indices, one per code/sub pair
  localparam int CERR_NEV = 20;
  localparam logic [15:0] CERR_EV_CODE [CERR_NEV] = '{
    16'h8100, 16'h8110, 16'h8120, 16'h8130, 16'h8140, 16'h8150,
    16'h8210, 16'h8220, 16'h8220, 16'h8220, 16'h8230, 16'h8301,
    16'h8310, 16'h8310, 16'h8310, 16'h8310, 16'h8310,
    16'h8320, 16'h8320, 16'h8320};
  localparam logic [7:0] CERR_EV_SUB [CERR_NEV] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h01, 8'h02, 8'h03, 8'h01, 8'h01,
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h01, 8'h02, 8'h03};
  localparam int CERR_EV_READ_FAIL = 15;
  // SDO abort causes and codes
  typedef enum logic [3:0] {
    CERR_AB_CMD = 4'h0, CERR_AB_ACCESS = 4'h1, CERR_AB_RD_WO = 4'h2,
    CERR_AB_WR_RO = 4'h3, CERR_AB_NO_OBJ = 4'h4, CERR_AB_OVERLOAD = 4'h5,
    CERR_AB_NO_SUB = 4'h6, CERR_AB_RANGE = 4'h7, CERR_AB_TOO_BIG = 4'h8,
    CERR_AB_GENERAL = 4'h9, CERR_AB_SIGN = 4'hA, CERR_AB_NO_STORE = 4'hB,
    CERR_AB_NO_DATA = 4'hC
  } cerr_abort_t;
  localparam logic [31:0] CERR_ABORT_CODE [13] = '{
    32'h05040001, 32'h06010000, 32'h06010001, 32'h06010002,
    32'h06020000, 32'h06060000, 32'h06090011, 32'h06090030,
    32'h06090031, 32'h08000000, 32'h08000020, 32'h08000021,
    32'h08000024};
  // Frame handed to the CAN controller
  typedef struct packed {
    logic [10:0] cob_id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cerr_frame_t;
  // APB request carrier
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } cerr_apb_t;
endpackage

// *** src/cerr_abort.sv ***
// SDO abort code lookup: turns a cause into its 32-bit code.
// Assumes the cause is held stable while the request strobe is high.
`timescale 1ns/100ps
module cerr_abort
  import cerr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic req,
  input wire logic [3:0] cause,
  // Result
  output logic [31:0] code,
  output logic valid
);
  logic [31:0] code_r, code_nxt;
  logic valid_r, valid_nxt;

  // Unknown causes fall back to the general error code
  always_comb begin
    code_nxt = code_r;
    valid_nxt = req;
    if (req) begin
      if (cause <= 4'hC) begin
        code_nxt = CERR_ABORT_CODE[cause];
      end else begin
        code_nxt = CERR_ABORT_CODE[CERR_AB_GENERAL];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_r <= 32'h00000000;
      valid_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign code = code_r;
  assign valid = valid_r;

  a_abort_general: assert property (@(posedge pclk) disable iff (!presetn)
    req && cause > 4'hC |=> code == 32'h08000000) else $error("bad fallback");
  a_abort_wo: assert property (@(posedge pclk) disable iff (!presetn)
    req && cause == 4'h2 |=> valid && code == 32'h06010001) else $error("bad wo");
endmodule // cerr_abort

// *** src/cerr_emcy_pick.sv ***
// Priority picker: lowest pending event index wins the next frame.
// Assumes pending bits are sticky and cleared by the caller.
`timescale 1ns/100ps
module cerr_emcy_pick
  import cerr_pkg::*;
#(
  parameter int NEV = CERR_NEV
)
(
  // Pending events
  input wire logic [NEV-1:0] pending,
  // Choice
  output logic found,
  output logic [4:0] index
);
  // Five index bits serve at most 32 events
  if (NEV > 32 || NEV < 1) begin : g_nev_check
    $error("NEV out of range");
  end

  // Scan high to low so the lowest index is left standing
  always_comb begin
    found = 1'b0;
    index = 5'h00;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found = 1'b1;
        index = 5'(i);
      end
    end
  end
endmodule // cerr_emcy_pick

// *** tb/cerr_can_model.sv ***
// Partner model: the CAN controller that takes frames from the error core.
// Assumes valid/ready transfers sampled on rising pclk edges.
`timescale 1ns/100ps
module cerr_can_model
  import cerr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Frame handshake
  input wire cerr_pkg::cerr_frame_t tx_frame,
  input wire logic tx_valid,
  output logic tx_ready,
  // Bench control and capture
  input wire logic slow,
  output logic got,
  output cerr_pkg::cerr_frame_t got_frame
);
  // Random stalls when slow, so the core must hold its frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      got <= 1'b0;
      got_frame <= '0;
    end else begin
      tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
      got <= tx_valid && tx_ready;
      if (tx_valid && tx_ready) begin
        got_frame <= tx_frame;
      end
    end
  end
endmodule // cerr_can_model

// *** tb/cerr_top_tb.sv ***
// Self-checking bench for the error core: APB master, event strobes.
// Assumes cerr_can_model as the frame sink and a 50 MHz pclk.
`timescale 1ns/100ps
module cerr_top_tb;
  import cerr_pkg::*;
  localparam logic [15:0] EXP_CODE [20] = '{16'h8100, 16'h8110, 16'h8120, 16'h8130,
    16'h8140, 16'h8150, 16'h8210, 16'h8220, 16'h8220, 16'h8220, 16'h8230, 16'h8301,
    16'h8310, 16'h8310, 16'h8310, 16'h8310, 16'h8310, 16'h8320, 16'h8320, 16'h8320};
  localparam logic [7:0] EXP_SUB [20] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h01, 8'h02, 8'h03};
  localparam logic [31:0] EXP_ABORT [16] = '{32'h05040001, 32'h06010000, 32'h06010001,
    32'h06010002, 32'h06020000, 32'h06060000, 32'h06090011, 32'h06090030, 32'h06090031,
    32'h08000000, 32'h08000020, 32'h08000021, 32'h08000024, 32'h08000000, 32'h08000000,
    32'h08000000};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cerr_frame_t tx_frame;
  cerr_frame_t got_frame;
  cerr_frame_t f;
  logic tx_valid;
  logic tx_ready;
  logic [CERR_NEV-1:0] ev_strobe = '0;
  logic rd_fail = 1'b0;
  logic rd_ok = 1'b0;
  logic [15:0] pdo_status;
  logic [15:0] pdo_detail;
  logic [7:0] err_register;
  logic slow = 1'b0;
  logic got;
  logic [6:0] node;
  logic [15:0] fv;
  logic [31:0] rd;
  logic er;
  logic [7:0] exp_er = 8'h00;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_frames = 0;
  int a;
  int b;
  int n0;

  cerr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .ev_strobe(ev_strobe), .rd_fail(rd_fail), .rd_ok(rd_ok), .pdo_status(pdo_status),
    .pdo_detail(pdo_detail), .err_register(err_register));
  cerr_can_model partner (.pclk(pclk), .presetn(presetn), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow), .got(got),
    .got_frame(got_frame));

  // Clock, frame counter and hang guard
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (got === 1'b1) n_frames++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse_ev(input logic [CERR_NEV-1:0] m);
    @(posedge pclk);
    ev_strobe <= m;
    @(posedge pclk);
    ev_strobe <= '0;
  endtask

  task automatic pulse_rd(input logic fail);
    @(posedge pclk);
    rd_fail <= fail;
    rd_ok <= !fail;
    @(posedge pclk);
    rd_fail <= 1'b0;
    rd_ok <= 1'b0;
  endtask

  task automatic wait_frame();
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge pclk);
      #1;
      if (got === 1'b1) break;
    end
    chk(64'(k < 300), 64'h1);
    f = got_frame;
  endtask

  task automatic chk_emcy(input int i);
    wait_frame();
    chk(64'(f.cob_id), 64'(11'h080 + 11'(node)));
    chk(64'(f.dlc), 64'h8);
    chk(f.data, {EXP_SUB[i], 32'h0, exp_er, EXP_CODE[i]});
  endtask

  initial begin
    void'($urandom(32'h813EF21D));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Boot-up frame first, default node 1
    wait_frame();
    chk({53'h0, f.cob_id}, 64'h701);
    chk(64'(f.dlc), 64'h1);
    chk(f.data, 64'h0);
    node = 7'($urandom_range(127, 1));
    apb(1'b1, CERR_OFF_CTRL, 32'(node));
    // A zero identifier is dropped, the written one stays
    apb(1'b1, CERR_OFF_CTRL, 32'h0);
    apb(1'b0, CERR_OFF_CTRL, 32'h0);
    chk(64'(rd), 64'(node));
    // Every event once, in a random rotation, partner sometimes stalling
    a = $urandom_range(19, 0);
    for (int k = 0; k < 20; k++) begin
      slow <= 1'($urandom % 2);
      pulse_ev(20'h00001 << ((k * 7 + a) % 20));
      chk_emcy((k * 7 + a) % 20);
    end
    // Two events together: lower index goes out first
    b = (a + 1 + $urandom_range(18, 0)) % 20;
    pulse_ev((20'h00001 << a) | (20'h00001 << b));
    chk_emcy(a < b ? a : b);
    chk_emcy(a < b ? b : a);
    // Functional fault shows in status, error register and PDOs
    fv = 16'($urandom_range(16'hFFFF, 1));
    apb(1'b1, CERR_OFF_FAULT, 32'(fv));
    exp_er = 8'h80;
    repeat (2) @(posedge pclk);
    chk(64'(pdo_status[14]), 64'h1);
    chk(64'(err_register[7]), 64'h1);
    chk(64'(pdo_detail), 64'(fv));
    apb(1'b0, CERR_OFF_STATUS, 32'h0);
    chk(64'(rd[14]), 64'h1);
    apb(1'b0, CERR_OFF_FAULT, 32'h0);
    chk(64'(rd[15:0]), 64'(fv));
    apb(1'b0, CERR_OFF_ERRREG, 32'h0);
    chk(64'(rd[7]), 64'h1);
    apb(1'b0, CERR_OFF_PDO, 32'h0);
    chk(64'(rd[31:16]), 64'(fv));
    pulse_ev(20'h00001);
    chk_emcy(0);
    chk(64'(f.data[23]), 64'h1);
    apb(1'b1, CERR_OFF_FAULT, 32'h0);
    exp_er = 8'h00;
    repeat (2) @(posedge pclk);
    chk(64'(pdo_status[14]), 64'h0);
    chk(64'(err_register[7]), 64'h0);
    // Every abort cause, reserved ones included
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, CERR_OFF_SDOREQ, 32'(c));
      apb(1'b0, CERR_OFF_ABORT, 32'h0);
      chk(64'(rd), 64'(EXP_ABORT[c]));
    end
    // Three fails, a success, three fails: still silent; a fourth raises it
    n0 = n_frames;
    repeat (3) pulse_rd(1'b1);
    pulse_rd(1'b0);
    repeat (3) pulse_rd(1'b1);
    repeat (20) @(posedge pclk);
    chk(64'(n_frames), 64'(n0));
    pulse_rd(1'b1);
    chk_emcy(CERR_EV_READ_FAIL);
    // Mid-run reset: boot-up frame again with the reset node identifier
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_frame();
    chk({53'h0, f.cob_id}, 64'h701);
    apb(1'b0, CERR_OFF_CTRL, 32'h0);
    chk(64'(rd), 64'(CERR_NODE_RST));
    // Unmapped address is refused both ways
    apb(1'b0, 8'hFC, 32'h0);
    chk(64'(er), 64'h1);
    apb(1'b1, 8'hF8, 32'h12345678);
    chk(64'(er), 64'h1);
    complete_run();
  end
endmodule // cerr_top_tb
